// ---- logic/charger_timer_boost_config_regs.sv ----
// termination/timer and boost/thermal configuration registers of the charger

module charger_timer_boost_config_regs #(
    parameter int unsigned WDOG_UNIT_CYCLES =
        32'(charger_cfg_pkg::WDOG_UNIT_CYCLES)
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register access from the serial host port
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [3:0] host_addr,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    // watchdog fault readout and its clear
    input wire logic wdog_fault_clear,
    output logic watchdog_fault,
    // raw fields to the charger control logic
    output logic term_enable,
    output logic [1:0] watchdog_period,
    output logic safety_timer_enable,
    output logic [1:0] fast_charge_time_limit,
    output logic [3:0] boost_output_level,
    output logic [1:0] boost_hot_threshold,
    output logic [1:0] thermal_regulation_threshold,
    // decoded settings
    output logic [7:0] watchdog_seconds,
    output logic [4:0] fast_charge_hours,
    output logic [12:0] boost_target_mv,
    output logic boost_hot_shutdown_en,
    output logic [5:0] boost_hot_pct,
    output logic [5:0] thermistor_fault_pct,
    output logic [6:0] thermal_regulation_degc
);

    ////////////////////////////////////////////////////////////////////////
    // register file
    logic [7:0] term_timer;
    logic [7:0] boost_therm;
    logic [7:0] next_term_timer;
    logic [7:0] next_boost_therm;
    logic [7:0] next_host_rdata;
    logic wr_term;
    logic wr_boost;

    // write decode; unmapped writes are dropped, unmapped reads give zero
    always_comb
    begin
        wr_term = host_wr && host_addr == charger_cfg_pkg::TERM_TIMER_IDX;
        wr_boost = host_wr && host_addr == charger_cfg_pkg::BOOST_THERM_IDX;
        next_term_timer = term_timer;
        next_boost_therm = boost_therm;
        // reserved bits stay zero whatever the host writes
        if (wr_term)
        begin
            next_term_timer = host_wdata & charger_cfg_pkg::TERM_TIMER_WMASK;
        end
        if (wr_boost)
        begin
            next_boost_therm = host_wdata & charger_cfg_pkg::BOOST_THERM_WMASK;
        end
        next_host_rdata = host_rdata;
        if (host_rd)
        begin
            unique case (host_addr)
                charger_cfg_pkg::TERM_TIMER_IDX: next_host_rdata = term_timer;
                charger_cfg_pkg::BOOST_THERM_IDX:
                    next_host_rdata = boost_therm;
                default: next_host_rdata = 8'h00;
            endcase
        end
    end

    // register storage; read data held until the next read
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            term_timer <= charger_cfg_pkg::TERM_TIMER_RESET;
            boost_therm <= charger_cfg_pkg::BOOST_THERM_RESET;
            host_rdata <= 8'h00;
        end
        else
        begin
            term_timer <= next_term_timer;
            boost_therm <= next_boost_therm;
            host_rdata <= next_host_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // field extraction, straight from the register flops
    always_comb
    begin
        term_enable = term_timer[charger_cfg_pkg::TERM_EN_POS];
        watchdog_period = term_timer[charger_cfg_pkg::WDOG_LSB +: 2];
        safety_timer_enable = term_timer[charger_cfg_pkg::SAFETY_EN_POS];
        fast_charge_time_limit =
            term_timer[charger_cfg_pkg::FAST_TIME_LSB +: 2];
        boost_output_level = boost_therm[charger_cfg_pkg::BOOST_LVL_LSB +: 4];
        boost_hot_threshold = boost_therm[charger_cfg_pkg::BOOST_HOT_LSB +: 2];
        thermal_regulation_threshold =
            boost_therm[charger_cfg_pkg::THERM_REG_LSB +: 2];
    end

    ////////////////////////////////////////////////////////////////////////
    // decoded settings, registered so the analogue side sees clean levels;
    // they trail a register write by one cycle
    logic [7:0] next_wdog_s;
    logic [4:0] next_hours;
    logic [12:0] next_mv;
    logic next_hot_en;
    logic [5:0] next_hot_pct;
    logic [6:0] next_degc;

    always_comb
    begin
        next_wdog_s = charger_cfg_pkg::wdog_seconds(watchdog_period);
        next_hours = charger_cfg_pkg::fast_hours(fast_charge_time_limit);
        next_mv = charger_cfg_pkg::boost_mv(boost_output_level);
        next_hot_en = boost_hot_threshold != charger_cfg_pkg::BOOST_HOT_OFF;
        next_hot_pct = charger_cfg_pkg::hot_pct(boost_hot_threshold);
        next_degc = charger_cfg_pkg::thermal_regulation_threshold_degc(thermal_regulation_threshold);
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            watchdog_seconds <= 8'h00;
            fast_charge_hours <= 5'h00;
            boost_target_mv <= 13'h0000;
            boost_hot_shutdown_en <= 1'b0;
            boost_hot_pct <= 6'h00;
            thermistor_fault_pct <= 6'h00;
            thermal_regulation_degc <= 7'h00;
        end
        else
        begin
            watchdog_seconds <= next_wdog_s;
            fast_charge_hours <= next_hours;
            boost_target_mv <= next_mv;
            boost_hot_shutdown_en <= next_hot_en;
            boost_hot_pct <= next_hot_pct;
            // fault level follows the boost hot cut-off percent
            thermistor_fault_pct <= next_hot_pct;
            thermal_regulation_degc <= next_degc;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // host-bus watchdog; any host access restarts it
    // watchdog fault source
    host_watchdog #(
        .UNIT_CYCLES(WDOG_UNIT_CYCLES)
    ) u_wdog (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .period_sel(watchdog_period),
        .kick(host_wr || host_rd),
        .fault_clear(wdog_fault_clear),
        .fault(watchdog_fault)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks
    logic out_of_reset;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_of_reset <= 1'b0;
        end
        else
        begin
            out_of_reset <= 1'b1;
        end
    end

    property p_reset_term;
        @(posedge core_clk) disable iff (!rst_n)
        !out_of_reset |-> term_timer == 8'h9C;
    endproperty
    a_reset_term: assert property (p_reset_term)
        else $error("termination register reset value wrong");

    property p_reset_boost;
        @(posedge core_clk) disable iff (!rst_n)
        !out_of_reset |-> boost_therm == 8'h93;
    endproperty
    a_reset_boost: assert property (p_reset_boost)
        else $error("boost register reset value wrong");

    sequence s_term_write;
        host_wr && host_addr == 4'h5;
    endsequence

    property p_term_write;
        @(posedge core_clk) disable iff (!rst_n)
        s_term_write |=> term_timer == ($past(host_wdata) & 8'hBE)
            && term_enable == $past(host_wdata[7])
            && safety_timer_enable == $past(host_wdata[3]);
    endproperty
    a_term_write: assert property (p_term_write)
        else $error("termination register write not applied");

    property p_reserved_zero;
        @(posedge core_clk) disable iff (!rst_n)
        term_timer[6] == 1'b0 && term_timer[0] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits not zero");

    property p_wdog_decode;
        @(posedge core_clk) disable iff (!rst_n)
        s_term_write ##1 !host_wr |=> watchdog_seconds ==
            (term_timer[5:4] == 2'h0 ? 8'h00 :
                8'h28 << (term_timer[5:4] - 2'h1));
    endproperty
    a_wdog_decode: assert property (p_wdog_decode)
        else $error("watchdog period decode wrong");

    property p_hours;
        @(posedge core_clk) disable iff (!rst_n)
        out_of_reset && $past(fast_charge_time_limit) == 2'h2
            |-> fast_charge_hours == 5'h0C;
    endproperty
    a_hours: assert property (p_hours)
        else $error("12 hour code not decoded");

    property p_boost_mv;
        @(posedge core_clk) disable iff (!rst_n)
        out_of_reset |-> boost_target_mv ==
            13'h11C6 + 13'({$past(boost_output_level), 6'h00});
    endproperty
    a_boost_mv: assert property (p_boost_mv)
        else $error("boost millivolt decode wrong");

    property p_hot_pct;
        @(posedge core_clk) disable iff (!rst_n)
        out_of_reset && $past(boost_hot_threshold) == 2'h1
            |-> boost_hot_pct == 6'h24 && boost_hot_shutdown_en;
    endproperty
    a_hot_pct: assert property (p_hot_pct)
        else $error("36 percent hot code not decoded");

    property p_hot_off;
        @(posedge core_clk) disable iff (!rst_n)
        out_of_reset && $past(boost_hot_threshold) == 2'h3
            |-> !boost_hot_shutdown_en && thermistor_fault_pct == 6'h21;
    endproperty
    a_hot_off: assert property (p_hot_off)
        else $error("hot shutdown not disabled for code 11");

    property p_thermal_regulation_threshold;
        @(posedge core_clk) disable iff (!rst_n)
        out_of_reset && $past(thermal_regulation_threshold) == 2'h0
            |-> thermal_regulation_degc == 7'h3C;
    endproperty
    a_thermal_regulation_threshold: assert property (p_thermal_regulation_threshold)
        else $error("60 C thermal code not decoded");

endmodule // charger_timer_boost_config_regs

// ---- common/charger_cfg_pkg.sv ----
// constants, field layout and decode helpers of the charger config registers
package charger_cfg_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register indices on the host port
    localparam logic [3:0] TERM_TIMER_IDX = 4'h5;
    localparam logic [3:0] BOOST_THERM_IDX = 4'h6;

    // values after reset
    localparam logic [7:0] TERM_TIMER_RESET = 8'h9C;
    localparam logic [7:0] BOOST_THERM_RESET = 8'h93;

    // writable bits; bits 6 and 0 of the first register are reserved
    localparam logic [7:0] TERM_TIMER_WMASK = 8'hBE;
    localparam logic [7:0] BOOST_THERM_WMASK = 8'hFF;

    // field positions, first register
    localparam int TERM_EN_POS = 7;
    localparam int WDOG_LSB = 4;
    localparam int SAFETY_EN_POS = 3;
    localparam int FAST_TIME_LSB = 1;

    // field positions, second register
    localparam int BOOST_LVL_LSB = 4;
    localparam int BOOST_HOT_LSB = 2;
    localparam int THERM_REG_LSB = 0;

    ////////////////////////////////////////////////////////////////////////
    // timing: shortest watchdog period, and the clock rate
    localparam longint WDOG_UNIT_S = 40;
    localparam longint CLK_HZ = 10_000_000;
    localparam longint WDOG_UNIT_CYCLES = WDOG_UNIT_S * CLK_HZ;

    // analogue scale figures
    localparam int BOOST_BASE_MV = 4550;
    localparam int BOOST_STEP_MV = 64;
    localparam logic [1:0] BOOST_HOT_OFF = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // watchdog period in seconds, zero when disabled
    function automatic logic [7:0] wdog_seconds(input logic [1:0] code);
        unique case (code)
            2'h0: wdog_seconds = 8'h00;
            2'h1: wdog_seconds = 8'h28;
            2'h2: wdog_seconds = 8'h50;
            2'h3: wdog_seconds = 8'hA0;
        endcase
    endfunction

    // fast-charge limit in hours
    function automatic logic [4:0] fast_hours(input logic [1:0] code);
        unique case (code)
            2'h0: fast_hours = 5'h05;
            2'h1: fast_hours = 5'h08;
            2'h2: fast_hours = 5'h0C;
            2'h3: fast_hours = 5'h14;
        endcase
    endfunction

    // boost target in millivolts
    function automatic logic [12:0] boost_mv(input logic [3:0] code);
        boost_mv = 13'(BOOST_BASE_MV) + 13'(code * BOOST_STEP_MV);
    endfunction

    // boost hot cut-off as percent of the regulator rail (off code -> 33)
    function automatic logic [5:0] hot_pct(input logic [1:0] code);
        unique case (code)
            2'h0: hot_pct = 6'h21;
            2'h1: hot_pct = 6'h24;
            2'h2: hot_pct = 6'h1E;
            2'h3: hot_pct = 6'h21;
        endcase
    endfunction

    // thermal regulation threshold in degrees celsius
    function automatic logic [6:0] thermal_regulation_threshold_degc(input logic [1:0] code);
        unique case (code)
            2'h0: thermal_regulation_threshold_degc = 7'h3C;
            2'h1: thermal_regulation_threshold_degc = 7'h50;
            2'h2: thermal_regulation_threshold_degc = 7'h64;
            2'h3: thermal_regulation_threshold_degc = 7'h78;
        endcase
    endfunction

endpackage

// ---- logic/host_watchdog.sv ----
// host-bus watchdog: counts idle time between host accesses
module host_watchdog #(
    parameter int unsigned UNIT_CYCLES = 32'h17D7_8400
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // control
    input wire logic [1:0] period_sel,
    input wire logic kick,
    input wire logic fault_clear,
    // status
    output logic fault
);

    ////////////////////////////////////////////////////////////////////////
    logic [31:0] count;
    logic [31:0] next_count;
    logic [31:0] limit;
    logic next_fault;
    logic expire;

    // period of 1, 2 or 4 units; sel 0 keeps the counter parked
    always_comb
    begin
        limit = 32'(UNIT_CYCLES) << (period_sel - 2'h1);
        expire = (period_sel != 2'h0) && !kick && (count >= limit - 32'h1);
        next_count = count + 32'h1;
        if (period_sel == 2'h0 || kick || expire)
        begin
            next_count = 32'h0;
        end
        next_fault = expire || (fault && !fault_clear);
    end

    // state registers
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= 32'h0;
            fault <= 1'b0;
        end
        else
        begin
            count <= next_count;
            fault <= next_fault;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_wdog_expire;
        @(posedge core_clk) disable iff (!rst_n)
        expire |=> fault && count == 32'h0;
    endproperty
    a_wdog_expire: assert property (p_wdog_expire)
        else $error("watchdog expiry did not raise fault");

    property p_wdog_quiet;
        @(posedge core_clk) disable iff (!rst_n)
        (period_sel == 2'h0) |=> count == 32'h0;
    endproperty
    a_wdog_quiet: assert property (p_wdog_quiet)
        else $error("disabled watchdog kept counting");

endmodule // host_watchdog

// ---- dv/test_charger_timer_boost_config_regs.sv ----
// self-checking bench for the charger termination/timer and boost registers
module test_charger_timer_boost_config_regs;
    timeunit 1ns;
    timeprecision 100ps;

    // short watchdog unit keeps the idle waits to a few dozen cycles
    localparam int unsigned UNIT = 16;
    localparam logic [3:0] T_IDX = charger_cfg_pkg::TERM_TIMER_IDX;
    localparam logic [3:0] B_IDX = charger_cfg_pkg::BOOST_THERM_IDX;

    // clock, reset and host port
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic host_wr = 1'b0;
    logic host_rd = 1'b0;
    logic [3:0] host_addr = 4'h0;
    logic [7:0] host_wdata = 8'h00;
    logic [7:0] host_rdata;
    logic wdog_fault_clear = 1'b0;
    logic watchdog_fault;
    // raw and decoded fields
    logic term_enable, safety_timer_enable, boost_hot_shutdown_en;
    logic [1:0] watchdog_period, fast_charge_time_limit;
    logic [1:0] boost_hot_threshold, thermal_regulation_threshold;
    logic [3:0] boost_output_level;
    logic [7:0] watchdog_seconds;
    logic [4:0] fast_charge_hours;
    logic [12:0] boost_target_mv;
    logic [5:0] boost_hot_pct, thermistor_fault_pct;
    logic [6:0] thermal_regulation_degc;
    int fail_count = 0;
    int checks_done = 0;

    // expected decodes, written out by hand per code
    logic [7:0] exp_sec [4] = '{8'h00, 8'h28, 8'h50, 8'hA0};
    logic [4:0] exp_hrs [4] = '{5'h05, 5'h08, 5'h0C, 5'h14};
    logic [5:0] exp_pct [4] = '{6'h21, 6'h24, 6'h1E, 6'h21};
    logic [6:0] exp_deg [4] = '{7'h3C, 7'h50, 7'h64, 7'h78};

    charger_timer_boost_config_regs #(.WDOG_UNIT_CYCLES(UNIT)) u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .host_wr(host_wr),
        .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .wdog_fault_clear(wdog_fault_clear),
        .watchdog_fault(watchdog_fault), .term_enable(term_enable),
        .watchdog_period(watchdog_period),
        .safety_timer_enable(safety_timer_enable),
        .fast_charge_time_limit(fast_charge_time_limit),
        .boost_output_level(boost_output_level),
        .boost_hot_threshold(boost_hot_threshold),
        .thermal_regulation_threshold(thermal_regulation_threshold),
        .watchdog_seconds(watchdog_seconds),
        .fast_charge_hours(fast_charge_hours),
        .boost_target_mv(boost_target_mv),
        .boost_hot_shutdown_en(boost_hot_shutdown_en),
        .boost_hot_pct(boost_hot_pct),
        .thermistor_fault_pct(thermistor_fault_pct),
        .thermal_regulation_degc(thermal_regulation_degc)
    );

    ////////////////////////////////////////////////////////////////////////
    // free-running 10 MHz clock
    always #50 core_clk = ~core_clk;

    // compare helpers, one per kind of result
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_val({15'h0000, got}, {15'h0000, exp});
    endtask

    // strobes rise after a falling edge and drop at the next one
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge core_clk);
        host_wr = 1'b1;
        host_addr = a;
        host_wdata = d;
        @(negedge core_clk);
        host_wr = 1'b0;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(negedge core_clk);
        host_rd = 1'b1;
        host_addr = a;
        @(negedge core_clk);
        host_rd = 1'b0;
        chk_val({8'h00, host_rdata}, {8'h00, exp});
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // raw fields plus their decodes, two cycles after the write settles
    task automatic chk_fields(input logic [7:0] t, input logic [7:0] b);
        idle(2);
        chk_bit(term_enable, t[7]);
        chk_val(16'(watchdog_period), 16'(t[5:4]));
        chk_val(16'(watchdog_seconds), 16'(exp_sec[t[5:4]]));
        chk_bit(safety_timer_enable, t[3]);
        chk_val(16'(fast_charge_hours), 16'(exp_hrs[t[2:1]]));
        chk_val(16'(fast_charge_time_limit), 16'(t[2:1]));
        chk_val(16'(boost_output_level), 16'(b[7:4]));
        chk_val(16'(boost_target_mv),
            16'h11C6 + 16'(b[7:4]) * 16'h0040);
        chk_val(16'(boost_hot_threshold), 16'(b[3:2]));
        chk_val(16'(boost_hot_pct), 16'(exp_pct[b[3:2]]));
        chk_bit(boost_hot_shutdown_en, b[3:2] != 2'h3);
        chk_val(16'(thermistor_fault_pct), 16'(exp_pct[b[3:2]]));
        chk_val(16'(thermal_regulation_threshold), 16'(b[1:0]));
        chk_val(16'(thermal_regulation_degc), 16'(exp_deg[b[1:0]]));
    endtask

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // hang guard, well beyond the roughly 600 cycles of the sequence
    initial
    begin
        #400_000;
        fail_count++;
        close_out();
    end

    // main sequence
    initial
    begin
        int n;
        idle(3);
        rst_n = 1'b1;
        chk_fields(8'h9C, 8'h93);
        rd_chk(T_IDX, 8'h9C);
        rd_chk(B_IDX, 8'h93);
        // reserved bits never stick, even when written as ones
        wr(T_IDX, 8'hFF);
        rd_chk(T_IDX, 8'hBE);
        // every code of each two-bit field, boost levels 0, 5, 10 and 15 only, the two writes one idle cycle apart
        for (int c = 0; c < 4; c++)
        begin
            wr(T_IDX, {c[0], 1'b0, c[1:0], c[1], c[1:0], 1'b0});
            wr(B_IDX, {c[1:0], c[1:0], c[1:0], c[1:0]});
            chk_fields({c[0], 1'b0, c[1:0], c[1], c[1:0], 1'b0},
                {c[1:0], c[1:0], c[1:0], c[1:0]});
            rd_chk(B_IDX, {c[1:0], c[1:0], c[1:0], c[1:0]});
        end
        // unmapped indices are ignored and read as zero
        wr(4'h7, 8'h5A);
        rd_chk(4'h7, 8'h00);
        rd_chk(B_IDX, 8'hFF);
        // write and read together: the read returns the old value
        @(negedge core_clk);
        host_wr = 1'b1;
        host_rd = 1'b1;
        host_addr = B_IDX;
        host_wdata = 8'h93;
        @(negedge core_clk);
        host_wr = 1'b0;
        host_rd = 1'b0;
        chk_val({8'h00, host_rdata}, 16'h00FF);
        // expiry time per period code; code 00 never expires
        for (int k = 0; k < 4; k++)
        begin
            @(negedge core_clk);
            wdog_fault_clear = 1'b1;
            @(negedge core_clk);
            wdog_fault_clear = 1'b0;
            wr(T_IDX, {2'b00, k[1:0], 4'h0});
            n = 0;
            while (watchdog_fault !== 1'b1 && n < 300)
            begin
                idle(1);
                n++;
            end
            if (k == 0)
                chk_bit(watchdog_fault, 1'b0);
            else
                chk_bit(n >= (UNIT << (k - 1)) - 3 &&
                    n <= (UNIT << (k - 1)) + 3, 1'b1);
        end
        // fault is sticky across accesses until cleared
        wr(T_IDX, 8'h00);
        idle(5);
        chk_bit(watchdog_fault, 1'b1);
        @(negedge core_clk);
        wdog_fault_clear = 1'b1;
        @(negedge core_clk);
        wdog_fault_clear = 1'b0;
        idle(1);
        chk_bit(watchdog_fault, 1'b0);
        // regular reads keep restarting a 40 s period
        wr(T_IDX, 8'h10);
        repeat (6)
        begin
            idle(10);
            rd_chk(B_IDX, 8'h93);
        end
        chk_bit(watchdog_fault, 1'b0);
        // second reset in mid-run restores both registers
        wr(B_IDX, 8'h00);
        @(negedge core_clk);
        rst_n = 1'b0;
        idle(2);
        chk_val(16'(boost_output_level), 16'h0009);
        chk_bit(watchdog_fault, 1'b0);
        rst_n = 1'b1;
        rd_chk(B_IDX, 8'h93);
        rd_chk(T_IDX, 8'h9C);
        close_out();
    end

endmodule // test_charger_timer_boost_config_regs
